// File: design/selc_pkg.sv
// Package: constants, states and carriers of the exception and low-power controller
package selc_pkg;
  // Interrupt sources, index 0 is the highest priority and the external pin
  localparam int          NSRC          = 8;
  localparam int          IDXW          = 3;
  localparam logic [2:0]  EXT_IRQ_IDX   = 3'h0;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_BRK_STAT  = 16'hfe00;
  localparam logic [15:0] IDX_RST_CAUSE = 16'hfe01;
  localparam logic [15:0] IDX_BRK_CLR   = 16'hfe03;
  // Reset cause register layout
  localparam logic [7:0]  CAUSE_RESET   = 8'h80;
  localparam int          CB_POR        = 7;
  localparam int          CB_PIN        = 6;
  localparam int          CB_COP        = 5;
  localparam int          CB_BAD_OPCODE_CAUSE_FLAG       = 4;
  localparam int          CB_BAD_FETCH_ADDRESS_CAUSE_FLAG       = 3;
  localparam int          CB_LVI        = 1;
  // Break registers layout
  localparam int          WAIT_EXIT_BY_BREAK_FLAG_BIT      = 1;
  localparam int          BREAK_FLAG_CLEAR_ENABLE_BIT      = 0;
  localparam logic        BREAK_FLAG_CLEAR_ENABLE_RESET    = 1'b0;
  // Stop recovery delay in crystal clock periods
  localparam int          STOP_DLY_XCLK = 4096;
  localparam int          DLYW          = 13;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_STACK   = 3'b001,
    ST_WAIT    = 3'b010,
    ST_STOP    = 3'b011,
    ST_STOPDLY = 3'b100
  } selc_state_t;

  // Core status seen by the controller
  typedef struct packed {
    logic instr_done;  // Instruction boundary pulse
    logic rti_done;    // Return instruction finished, next opcode prefetched
    logic swi_exec;    // Software trap executing
    logic wait_exec;   // Wait instruction executing
    logic stop_exec;   // Stop instruction executing
    logic stack_done;  // Core finished pushing its registers
    logic ibit;        // Interrupt mask bit
  } selc_core_in_t;

  // Requests toward the core
  typedef struct packed {
    logic            stack_req;  // Push registers, no index high byte
    logic            pc_dec;     // Stack PC minus one
    logic [IDXW-1:0] vec_idx;    // Arbitration result
    logic            vec_swi;    // Use the trap vector
    logic            ibit_set;   // Set mask after stacking
    logic            ibit_clr;   // Clear mask on low-power entry
  } selc_core_out_t;

  // Reset sources
  typedef struct packed {
    logic por;
    logic pin;
    logic watchdog_cause_flag;
    logic bad_opcode_cause_flag;
    logic bad_fetch_address_cause_flag;
    logic undervoltage_cause_flag;
  } selc_rst_src_t;
endpackage

// File: design/selc_prio.sv
// Fixed-priority picker of pending interrupt sources
`timescale 1ns/1ps
`default_nettype none
module selc_prio
  import selc_pkg::*;
(
  input  wire logic [NSRC-1:0] pend,
  output logic                 any,
  output logic [IDXW-1:0]      idx
);
  // Lowest index wins, scanned from the top so the last hit is kept
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        any = 1'b1;
        idx = IDXW'(i);
      end
    end
  end
endmodule
`default_nettype wire

// File: design/selc_ctl.sv
// Exception arbitration, low-power sequencing and status registers
// Notes on behaviour
// - Core stacks registers, then mask is set
// - Latch requests, give core constant vector index
// - Latched interrupt holds until serviced
// - Hardware interrupts wait for instruction end
// - Take only if unmasked and source enabled
// - Highest priority pending is serviced first
// - Pending at return served before next instruction
// - Index high byte never stacked on entry
// - Software trap ignores the mask bit
// - Trap stacks PC, hardware stacks PC minus one
// - Any reset source wins, skipping arbitration
// - Break protects flags unless clear enable set
// - Flag cleared in break stays cleared
// - Two-step clears protected across break
// - Low-power entry stops core, clears mask
// - Wait keeps peripherals, interrupt wakes next cycle
// - Reset or break ends wait, break sets flag
// - Watchdog runs in wait unless disabled
// - Stop clears prescaler, gates clocks, delayed wake
// - Reset or break ends stop mode
// - Wait-break flag cleared by zero write, reset
// - Cause register layout, read clears, power-on value
`timescale 1ns/1ps
`default_nettype none
module selc_ctl
  import selc_pkg::*;
(
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic      [31:0]    hrdata,
  output logic                hreadyout,
  output logic                hresp,
  input  wire selc_core_in_t  core_in,
  output selc_core_out_t      core_out,
  input  wire logic [NSRC-1:0] irq_req,
  input  wire logic [NSRC-1:0] irq_en,
  input  wire selc_rst_src_t  rst_src,
  input  wire logic           break_active,
  input  wire logic           break_req,
  input  wire logic           xclk_en,
  input  wire logic           watchdog_disable_bit,
  output logic                sys_rst,
  output logic                cpu_clk_en,
  output logic                periph_clk_en,
  output logic                cgm_en,
  output logic                prescale_clr,
  output logic                watchdog_run,
  output logic                flag_clear_en
);
  selc_state_t     state_r;
  selc_core_out_t  core_r;
  logic            lat_v_r;
  logic [IDXW-1:0] lat_idx_r;
  logic            lat_swi_r;
  logic [DLYW-1:0] dly_r;
  logic [7:0]      cause_r;
  logic            wait_exit_by_break_flag_r;
  logic            break_flag_clear_enable_r;
  logic            ap_wr_r;
  logic [15:0]     ap_idx_r;
  logic [31:0]     rdata_r;
  logic            hready_r;
  logic            sysrst_r;
  logic            cpuclk_r;
  logic            perclk_r;
  logic            cgm_r;
  logic            presc_r;
  logic            wdog_r;
  logic            fce_r;
  logic [NSRC-1:0] pend;
  logic            pend_any;
  logic [IDXW-1:0] pend_idx;
  logic            rst_any;
  logic            ap_take;
  logic            boundary;
  logic            wr_brk_stat;
  logic [7:0]      cause_nxt;

  // Register index from a byte address
  function automatic logic [15:0] reg_index(input logic [31:0] a);
    return a[17:2];
  endfunction

  // Only enabled sources compete
  assign pend     = irq_req & irq_en;
  assign rst_any  = |rst_src;
  assign boundary = core_in.instr_done | core_in.rti_done;
  assign ap_take  = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign wr_brk_stat = ap_wr_r & (ap_idx_r == IDX_BRK_STAT);

  selc_prio u_prio (
    .pend (pend),
    .any  (pend_any),
    .idx  (pend_idx)
  );

  // Cause layout; power-on overrides every other source
  always_comb begin
    cause_nxt = 8'h00;
    cause_nxt[CB_PIN]  = rst_src.pin;
    cause_nxt[CB_COP]  = rst_src.watchdog_cause_flag;
    cause_nxt[CB_BAD_OPCODE_CAUSE_FLAG] = rst_src.bad_opcode_cause_flag;
    cause_nxt[CB_BAD_FETCH_ADDRESS_CAUSE_FLAG] = rst_src.bad_fetch_address_cause_flag;
    cause_nxt[CB_LVI]  = rst_src.undervoltage_cause_flag;
    if (rst_src.por) begin
      cause_nxt = CAUSE_RESET;
    end
  end

  // Sequencer: resets bypass arbitration and end any low-power mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r   <= ST_RUN;
      lat_v_r   <= 1'b0;
      lat_idx_r <= '0;
      lat_swi_r <= 1'b0;
      dly_r     <= '0;
      cpuclk_r  <= 1'b1;
      perclk_r  <= 1'b1;
      cgm_r     <= 1'b1;
    end else if (rst_any) begin
      state_r   <= ST_RUN;
      lat_v_r   <= 1'b0;
      lat_swi_r <= 1'b0;
      cpuclk_r  <= 1'b1;
      perclk_r  <= 1'b1;
      cgm_r     <= 1'b1;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (core_in.swi_exec) begin
            // Trap is taken whatever the mask says
            lat_v_r   <= 1'b1;
            lat_swi_r <= 1'b1;
            state_r   <= ST_STACK;
          end else if (core_in.wait_exec) begin
            cpuclk_r <= 1'b0;
            state_r  <= ST_WAIT;
          end else if (core_in.stop_exec) begin
            cpuclk_r <= 1'b0;
            perclk_r <= 1'b0;
            cgm_r    <= 1'b0;
            state_r  <= ST_STOP;
          end else if (boundary && !core_in.ibit && (lat_v_r || pend_any)) begin
            // A latched request keeps its place against newer ones
            if (!lat_v_r) begin
              lat_idx_r <= pend_idx;
            end
            lat_v_r   <= 1'b1;
            lat_swi_r <= 1'b0;
            state_r   <= ST_STACK;
          end
        end
        ST_STACK: begin
          // Service complete once the core has pushed its registers
          if (core_in.stack_done) begin
            lat_v_r   <= 1'b0;
            lat_swi_r <= 1'b0;
            state_r   <= ST_RUN;
          end
        end
        ST_WAIT: begin
          if (break_req) begin
            cpuclk_r <= 1'b1;
            state_r  <= ST_RUN;
          end else if (pend_any) begin
            // Stacking starts on the next cycle
            lat_v_r   <= 1'b1;
            lat_idx_r <= pend_idx;
            lat_swi_r <= 1'b0;
            cpuclk_r  <= 1'b1;
            state_r   <= ST_STACK;
          end
        end
        ST_STOP: begin
          if (break_req) begin
            cpuclk_r <= 1'b1;
            perclk_r <= 1'b1;
            cgm_r    <= 1'b1;
            state_r  <= ST_RUN;
          end else if (irq_req[EXT_IRQ_IDX] && irq_en[EXT_IRQ_IDX]) begin
            // Oscillator restarts; stacking waits for it to settle
            cgm_r   <= 1'b1;
            dly_r   <= '0;
            state_r <= ST_STOPDLY;
          end
        end
        ST_STOPDLY: begin
          if (break_req) begin
            cpuclk_r <= 1'b1;
            perclk_r <= 1'b1;
            state_r  <= ST_RUN;
          end else if (xclk_en) begin
            if (dly_r == DLYW'(STOP_DLY_XCLK - 1)) begin
              lat_v_r   <= 1'b1;
              lat_idx_r <= EXT_IRQ_IDX;
              lat_swi_r <= 1'b0;
              cpuclk_r  <= 1'b1;
              perclk_r  <= 1'b1;
              state_r   <= ST_STACK;
            end else begin
              dly_r <= dly_r + DLYW'(1);
            end
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // Requests to the core; only PC, A, X and CCR are pushed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_r <= '0;
    end else begin
      core_r.stack_req <= (state_r == ST_STACK) && !core_in.stack_done && !rst_any;
      core_r.pc_dec    <= !lat_swi_r;
      core_r.vec_idx   <= lat_idx_r;
      core_r.vec_swi   <= lat_swi_r;
      core_r.ibit_set  <= (state_r == ST_STACK) && core_in.stack_done && !rst_any;
      core_r.ibit_clr  <= (state_r == ST_RUN) && !rst_any && !core_in.swi_exec
                          && (core_in.wait_exec || core_in.stop_exec);
    end
  end

  // Internal reset pulse and stop-entry prescaler clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysrst_r <= 1'b1;
      presc_r  <= 1'b0;
    end else begin
      sysrst_r <= rst_any;
      presc_r  <= (state_r == ST_RUN) && !rst_any && !core_in.swi_exec
                  && !core_in.wait_exec && core_in.stop_exec;
    end
  end

  // Watchdog enable and flag-clear permission for other modules
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_r <= 1'b0;
      fce_r  <= 1'b1;
    end else begin
      wdog_r <= !watchdog_disable_bit;
      // Peripherals gate both steps of a clear with this, so a first step
      // taken before break cannot complete inside it
      fce_r  <= !break_active || break_flag_clear_enable_r;
    end
  end

  // Bus address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r  <= 1'b0;
      ap_idx_r <= '0;
      hready_r <= 1'b0;
      rdata_r  <= '0;
    end else begin
      hready_r <= 1'b1;
      ap_wr_r  <= ap_take && hwrite && (hsize == 3'h2);
      ap_idx_r <= reg_index(haddr);
      rdata_r  <= '0;
      if (ap_take && !hwrite) begin
        unique case (reg_index(haddr))
          IDX_RST_CAUSE: rdata_r <= {24'h000000, cause_r};
          IDX_BRK_STAT:  rdata_r <= {30'h0, wait_exit_by_break_flag_r, 1'b0};
          IDX_BRK_CLR:   rdata_r <= {31'h0, break_flag_clear_enable_r};
          default:       rdata_r <= '0;
        endcase
      end
    end
  end

  // Reset cause flags: a new reset wins over the read that clears them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_r <= CAUSE_RESET;
    end else if (rst_any) begin
      cause_r <= cause_nxt;
    end else if (ap_take && !hwrite && reg_index(haddr) == IDX_RST_CAUSE) begin
      cause_r <= 8'h00;
    end
  end

  // Wait-exit-by-break flag; set beats a clearing write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_exit_by_break_flag_r <= 1'b0;
    end else if (rst_any) begin
      wait_exit_by_break_flag_r <= 1'b0;
    end else if (state_r == ST_WAIT && break_req) begin
      wait_exit_by_break_flag_r <= 1'b1;
    end else if (wr_brk_stat && !hwdata[WAIT_EXIT_BY_BREAK_FLAG_BIT]) begin
      wait_exit_by_break_flag_r <= 1'b0;
    end
  end

  // Break clear enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      break_flag_clear_enable_r <= BREAK_FLAG_CLEAR_ENABLE_RESET;
    end else if (rst_any) begin
      break_flag_clear_enable_r <= BREAK_FLAG_CLEAR_ENABLE_RESET;
    end else if (ap_wr_r && ap_idx_r == IDX_BRK_CLR) begin
      break_flag_clear_enable_r <= hwdata[BREAK_FLAG_CLEAR_ENABLE_BIT];
    end
  end

  assign hrdata        = rdata_r;
  assign hreadyout     = hready_r;
  assign hresp         = 1'b0;
  assign core_out      = core_r;
  assign sys_rst       = sysrst_r;
  assign cpu_clk_en    = cpuclk_r;
  assign periph_clk_en = perclk_r;
  assign cgm_en        = cgm_r;
  assign prescale_clr  = presc_r;
  assign watchdog_run  = wdog_r;
  assign flag_clear_en = fce_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_TRAP_NO_MASK: assert property ((state_r == ST_RUN && core_in.swi_exec && !rst_any) |=>
    (state_r == ST_STACK && lat_swi_r)) else $error("trap not taken");
  AST_MASK_BLOCKS: assert property ((state_r == ST_RUN && core_in.ibit && !core_in.swi_exec && !core_in.wait_exec
    && !core_in.stop_exec) |=> state_r != ST_STACK) else $error("masked interrupt taken");
  AST_NO_MID_INSTR: assert property ((state_r == ST_RUN && !boundary && !core_in.swi_exec) |=>
    state_r != ST_STACK) else $error("interrupt taken mid instruction");
  AST_LATCH_HOLD: assert property ((state_r == ST_STACK && !core_in.stack_done && !rst_any) |=>
    $stable(lat_idx_r) && lat_v_r) else $error("latched interrupt displaced");
  AST_PRIO: assert property ((state_r == ST_RUN && boundary && !core_in.ibit && !lat_v_r && pend_any
    && !core_in.swi_exec && !core_in.wait_exec && !core_in.stop_exec && !rst_any) |=>
    lat_idx_r == $past(pend_idx)) else $error("wrong priority");
  AST_PC_DEC: assert property ((state_r == ST_STACK) |=> core_r.pc_dec == !$past(lat_swi_r))
    else $error("wrong stacked PC");
  AST_RESET_WINS: assert property (rst_any |=> state_r == ST_RUN && !lat_v_r && sysrst_r)
    else $error("reset did not win");
  AST_WAIT_WAKE: assert property ((state_r == ST_WAIT && pend_any && !break_req && !rst_any) |=>
    state_r == ST_STACK ##1 (core_r.stack_req || $past(core_in.stack_done) || $past(rst_any))) else $error("slow wake");
  AST_WAIT_PERIPH: assert property (state_r == ST_WAIT |-> perclk_r && !cpuclk_r)
    else $error("wait clocks wrong");
  AST_BREAK_FLAG: assert property ((state_r == ST_WAIT && break_req && !rst_any) |=> wait_exit_by_break_flag_r)
    else $error("break exit flag not set");
  AST_FLAG_PROT: assert property ((break_active && !break_flag_clear_enable_r) |=> !fce_r)
    else $error("flags unprotected in break");
  AST_STOP_DELAY: assert property ((state_r == ST_STOPDLY && dly_r != DLYW'(STOP_DLY_XCLK - 1) && !rst_any
    && !break_req) |=> state_r == ST_STOPDLY) else $error("stop wake too early");
  AST_CAUSE_RC: assert property ((ap_take && !hwrite && reg_index(haddr) == IDX_RST_CAUSE && !rst_any) |=>
    rdata_r[7:0] == $past(cause_r) && cause_r == 8'h00) else $error("cause read clear wrong");
  AST_WDOG: assert property (!watchdog_disable_bit |=> wdog_r) else $error("watchdog stopped");

  COV_HW_INT: cover property (state_r == ST_RUN ##1 state_r == ST_STACK ##[1:20] core_r.ibit_set);
  COV_WAIT_WAKE: cover property (state_r == ST_WAIT ##1 state_r == ST_STACK);
  COV_STOP_WAKE: cover property (state_r == ST_STOPDLY ##1 state_r == ST_STACK);
  COV_BREAK_EXIT: cover property (state_r == ST_WAIT && break_req);
endmodule
`default_nettype wire

// File: verif/selc_core_model.sv
// Behavioural processor core facing the exception and low-power controller
`timescale 1ns/1ps
`default_nettype none
module selc_core_model
  import selc_pkg::*;
(
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire selc_core_out_t core_out,
  input  wire logic [4:0]     ev,
  input  wire logic [3:0]     stall,
  input  wire logic           mask_wr,
  input  wire logic           mask_val,
  output selc_core_in_t       core_in,
  output logic [7:0]          stack_cnt
);
  logic [3:0] cnt_r;
  logic       done_r;
  logic       ibit_r;

  // Boundary, return, trap, wait and stop pulses come straight from the bench
  assign core_in = {ev, done_r, ibit_r};

  // Stacking takes stall+1 cycles; the index high byte is never pushed here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r     <= 4'h0;
      done_r    <= 1'b0;
      stack_cnt <= 8'h00;
    end else if (done_r) begin
      // Request is still high for one edge after the done pulse, so skip it
      done_r <= 1'b0;
      cnt_r  <= 4'h0;
    end else if (core_out.stack_req) begin
      if (cnt_r == stall) begin
        done_r    <= 1'b1;
        stack_cnt <= stack_cnt + 8'h01;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // Mask bit: set after stacking, cleared on low-power entry, else as software leaves it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ibit_r <= 1'b1;
    end else if (mask_wr) begin
      ibit_r <= mask_val;
    end else if (core_out.ibit_set) begin
      ibit_r <= 1'b1;
    end else if (core_out.ibit_clr) begin
      ibit_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verif/selc_ctl_test.sv
// Self-checking bench of the exception and low-power controller
`timescale 1ns/1ps
`default_nettype none
module selc_ctl_test;
  import selc_pkg::*;
  typedef struct packed {
    logic [7:0] req;
    logic [7:0] en;
    logic       mask;
    logic [4:0] ev;
    logic       take;
    logic [2:0] idx;
  } selc_row_t;

  logic           hclk, hresetn, hsel, hwrite, mask_wr, mask_val;
  logic [31:0]    haddr, hwdata, hrdata;
  logic [1:0]     htrans;
  logic [2:0]     hsize;
  logic           hreadyout, hresp, break_active, break_req, xclk_en, wdis;
  logic           sys_rst, cpu_clk_en, periph_clk_en, cgm_en, prescale_clr, watchdog_run, flag_clear_en;
  logic [7:0]     irq_req, irq_en, stack_cnt;
  logic [5:0]     rst_src;
  logic [4:0]     ev;
  logic [3:0]     stall;
  selc_core_in_t  core_in;
  selc_core_out_t core_out;
  int             fail_count, num_checks, cyc, n;
  logic [7:0]     cause_exp [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
  // Ordinary arbitration cases: request, enable, mask, boundary pulse, taken, vector
  selc_row_t rows [8] = '{
    '{8'h04, 8'hff, 1'b0, 5'h10, 1'b1, 3'h2},
    '{8'h14, 8'hff, 1'b0, 5'h10, 1'b1, 3'h2},
    '{8'h14, 8'hfb, 1'b0, 5'h10, 1'b1, 3'h4},
    '{8'h80, 8'h7f, 1'b0, 5'h10, 1'b0, 3'h0},
    '{8'h04, 8'hff, 1'b1, 5'h10, 1'b0, 3'h0},
    '{8'h04, 8'hff, 1'b0, 5'h00, 1'b0, 3'h0},
    '{8'h81, 8'hff, 1'b0, 5'h08, 1'b1, 3'h0},
    '{8'h80, 8'h80, 1'b0, 5'h08, 1'b1, 3'h7}};

  selc_ctl u_selc_ctl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .core_in(core_in), .core_out(core_out), .irq_req(irq_req), .irq_en(irq_en),
    .rst_src(rst_src), .break_active(break_active), .break_req(break_req), .xclk_en(xclk_en),
    .watchdog_disable_bit(wdis), .sys_rst(sys_rst), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .cgm_en(cgm_en), .prescale_clr(prescale_clr),
    .watchdog_run(watchdog_run), .flag_clear_en(flag_clear_en));

  selc_core_model u_selc_core_model (
    .hclk(hclk), .hresetn(hresetn), .core_out(core_out), .ev(ev), .stall(stall),
    .mask_wr(mask_wr), .mask_val(mask_val), .core_in(core_in), .stack_cnt(stack_cnt));

  always #5 hclk = ~hclk;

  task automatic complete_run;
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Longest test is the stop recovery; the ceiling leaves ample room around it
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // One single word transfer; waits on the slave's ready, never on a fixed count
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {14'h0000, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, idx, d, t);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input string m);
    logic [31:0] t;
    bus(1'b0, idx, 32'h0000_0000, t);
    chk(t, exp, m);
  endtask

  task automatic pulse(input logic [4:0] e);
    @(posedge hclk);
    ev <= e;
    @(posedge hclk);
    ev <= 5'h00;
  endtask

  task automatic brk;
    @(posedge hclk);
    break_req <= 1'b1;
    @(posedge hclk);
    break_req <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
  endtask

  task automatic setirq(input logic [7:0] r, input logic [7:0] e, input logic m);
    @(posedge hclk);
    irq_req  <= r;
    irq_en   <= e;
    mask_wr  <= 1'b1;
    mask_val <= m;
    @(posedge hclk);
    mask_wr <= 1'b0;
  endtask

  task automatic wait_stack(input int lim, output int k);
    k = 0;
    #1;
    while (core_out.stack_req !== 1'b1 && k < lim) begin
      @(posedge hclk);
      #1;
      k++;
    end
  endtask

  task automatic wait_low;
    int k;
    k = 0;
    while (core_out.stack_req === 1'b1 && k < 40) begin
      @(posedge hclk);
      #1;
      k++;
    end
    repeat (2) @(posedge hclk);
    #1;
  endtask

  initial begin
    {hclk, hsel, hwrite, mask_wr, mask_val, break_active, break_req, wdis} = '0;
    {haddr, hwdata, htrans, irq_req, irq_en, rst_src, ev} = '0;
    {fail_count, num_checks, cyc} = '0;
    hsize   = 3'h2;
    xclk_en = 1'b1;
    stall   = 4'h2;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(IDX_RST_CAUSE, 32'h80, "cause after power-on");
    rdchk(IDX_RST_CAUSE, 32'h00, "cause not cleared");
    rdchk(IDX_BRK_STAT, 32'h00, "break status reset");
    rdchk(IDX_BRK_CLR, 32'h00, "clear control reset");
    rdchk(16'hfe02, 32'h00, "unmapped read");
    chk(watchdog_run, 1'b1, "watchdog stopped");
    chk({sys_rst, hresp}, 2'b00, "idle reset or response");
    // Table of arbitration cases
    foreach (rows[i]) begin
      setirq(rows[i].req, rows[i].en, rows[i].mask);
      repeat (2) @(posedge hclk);
      pulse(rows[i].ev);
      wait_stack(6, n);
      chk(n < 6, rows[i].take, "interrupt taken");
      if (n < 6) begin
        chk(core_out.vec_idx, rows[i].idx, "vector index");
        chk(core_out.pc_dec, 1'b1, "hardware pc stack");
        chk(core_out[2], 1'b0, "trap vector on hw");
        wait_low;
        chk(core_in.ibit, 1'b1, "mask after stacking");
      end
      @(posedge hclk);
      irq_req <= 8'h00;
    end
    // Latched request holds while a higher one arrives, slow core
    stall <= 4'h8;
    setirq(8'h10, 8'hff, 1'b0);
    pulse(5'h10);
    wait_stack(6, n);
    @(posedge hclk);
    irq_req <= 8'h11;
    repeat (4) @(posedge hclk);
    #1;
    chk(core_out.vec_idx, 3'h4, "latched displaced");
    wait_low;
    stall <= 4'h2;
    // Trap with the mask set
    setirq(8'h00, 8'hff, 1'b1);
    pulse(5'h04);
    wait_stack(6, n);
    chk(n < 6, 1'b1, "trap refused");
    chk(core_out[2], 1'b1, "trap vector");
    chk(core_out.pc_dec, 1'b0, "trap pc stack");
    wait_low;
    // Wait mode woken by an enabled interrupt
    pulse(5'h02);
    repeat (2) @(posedge hclk);
    #1;
    chk(cpu_clk_en, 1'b0, "core clock in wait");
    chk(periph_clk_en, 1'b1, "periph clock in wait");
    chk(core_in.ibit, 1'b0, "mask kept in wait");
    chk(watchdog_run, 1'b1, "watchdog in wait");
    setirq(8'h08, 8'hff, 1'b0);
    wait_stack(4, n);
    chk(n < 4, 1'b1, "wait wake late");
    chk(cpu_clk_en, 1'b1, "core clock after wake");
    wait_low;
    irq_req <= 8'h00;
    // Wait ended by break sets the status flag; zero write clears it
    pulse(5'h02);
    brk;
    chk(cpu_clk_en, 1'b1, "break left wait");
    rdchk(IDX_BRK_STAT, 32'h02, "wait break flag");
    wr(IDX_BRK_STAT, 32'h0);
    rdchk(IDX_BRK_STAT, 32'h00, "flag zero write");
    pulse(5'h02);
    brk;
    // Stop mode, external wake after the recovery delay
    setirq(8'h00, 8'h01, 1'b1);
    pulse(5'h01);
    #1;
    chk({prescale_clr, cpu_clk_en, periph_clk_en}, 3'b100, "stop entry");
    @(posedge hclk);
    irq_req <= 8'h01;
    wait_stack(4200, n);
    chk(n >= STOP_DLY_XCLK && n < STOP_DLY_XCLK + 12, 1'b1, "stop delay");
    chk(core_out.vec_idx, EXT_IRQ_IDX, "stop vector");
    wait_low;
    irq_req <= 8'h00;
    pulse(5'h01);
    brk;
    chk({cgm_en, cpu_clk_en}, 2'b11, "break left stop");
    // Flag protection in break
    break_active <= 1'b1;
    wdis         <= 1'b1;
    repeat (3) @(posedge hclk);
    #1;
    chk(flag_clear_en, 1'b0, "flags unprotected");
    chk(watchdog_run, 1'b0, "watchdog disable");
    wr(IDX_BRK_CLR, 32'h1);
    rdchk(IDX_BRK_CLR, 32'h01, "clear enable readback");
    chk(flag_clear_en, 1'b1, "clear enable ignored");
    wr(IDX_BRK_CLR, 32'h0);
    @(posedge hclk);
    break_active <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    chk(flag_clear_en, 1'b1, "flags locked after break");
    // Reset source during stacking, then every source in turn
    stall <= 4'hf;
    setirq(8'h04, 8'hff, 1'b0);
    pulse(5'h10);
    wait_stack(6, n);
    @(posedge hclk);
    rst_src <= 6'h04;
    @(posedge hclk);
    rst_src <= 6'h00;
    irq_req <= 8'h00;
    repeat (2) @(posedge hclk);
    #1;
    chk(core_out.stack_req, 1'b0, "reset left stacking");
    rdchk(IDX_BRK_STAT, 32'h00, "flag after reset");
    for (int k = 0; k < 6; k++) begin
      @(posedge hclk);
      rst_src <= 6'h20 >> k;
      @(posedge hclk);
      rst_src <= 6'h00;
      #1;
      chk(sys_rst, 1'b1, "internal reset");
      rdchk(IDX_RST_CAUSE, {24'h0, cause_exp[k]}, "cause flag");
    end
    // Nine services complete; the one cut by a reset source never finishes
    chk(stack_cnt, 8'h09, "stacking count");
    complete_run;
  end
endmodule
`default_nettype wire
